/* File: design/mcgs_regs.svh */
// register map, field positions, reset values and counts of the clock generator/select block
// Functional notes
// [R1] low-power select set disables the FLL in the two bypass modes
// [R2] internal reference speed select: 0 slow clock, 1 fast clock
// [R3] status bit 4 shows FLL reference source after synchronisation
// [R4] status bits 3-2 show active clock mode after synchronisation; 11 reserved
// [R5] oscillator ready resets 0, sets after init cycles, clears when disabled
// [R6] status bit 0 shows internal reference speed, updated only while enabled
// [R7] UART source bits 27-26: off, FLL, external osc ref, internal ref
// [R8] timer/PWM source bits 25-24 use the same four-way encoding
// [R9] clock output bits 7-5: 010 bus, 011 1 kHz, 100 int ref, 110 ext ref
// [R10] bit 4 selects 1 Hz RTC clock or external osc ref for RTC pin
// [R11] bit 7 fine-tunes the DCO for a 32.768 kHz reference
// [R12] DCO range bits 6-5, reset low; status follows after synchronisation
// [R13] writes to DCO range are ignored while low-power select is set
// [R14] fast reference trim bits 4-1, binary weighted, larger means longer period
// [R15] slow reference fine trim bit 0 lengthens period when set
// [R16] reserved bits read as zero and ignore writes
// [R17] software sets up the oscillator, selects external reference, polls ready
// [R18] oscillator output gated until 4096 crystal input cycles are counted
// [R19] low-power select moves bypassed modes into their low-power variants
// [R20] mirrored status fields pass through a two-stage synchroniser
`ifndef MCGS_REGS_SVH
`define MCGS_REGS_SVH
`define MCGS_A_CTRL        8'h00
`define MCGS_A_OSC         8'h04
`define MCGS_A_STAT        8'h08
`define MCGS_A_DCO         8'h0C
`define MCGS_A_PSEL        8'h10
`define MCGS_CTRL_MASK     32'h0000_03FF
`define MCGS_CTRL_RST      32'h0000_0100
`define MCGS_OSC_MASK      32'h0000_00A0
`define MCGS_DCO_MASK      32'h0000_00FF
`define MCGS_DCO_RST       32'h0000_0000
`define MCGS_PSEL_MASK     32'h0F00_00F0
`define MCGS_PSEL_RST      32'h0000_0000
`define MCGS_OSC_EN_BIT    7
`define MCGS_DCO_RNG_MASK  32'h0000_0060
`define MCGS_DRS_LSB       5
`define MCGS_UART_LSB      26
`define MCGS_TPM_LSB       24
`define MCGS_CLKO_LSB      5
`define MCGS_RTC_BIT       4
`define MCGS_INIT_CYCLES   4096
`define MCGS_SRC_FLL       0
`define MCGS_SRC_EXT       1
`define MCGS_SRC_IRS       2
`define MCGS_SRC_IRF       3
`define MCGS_SRC_LPO       4
`define MCGS_SRC_RTC       5
`define MCGS_NSRC          6
`endif

/* File: design/mcgs_pkg.sv */
// types shared by the clock generator/select block
package mcgs_pkg;
  typedef enum logic [2:0] {
    MCGS_FEI  = 3'b000,
    MCGS_FEE  = 3'b001,
    MCGS_FBI  = 3'b010,
    MCGS_FBE  = 3'b011,
    MCGS_BYPASSED_LOW_POWER_INTERNAL_MODE = 3'b100,
    MCGS_BYPASSED_LOW_POWER_EXTERNAL_MODE = 3'b101
  } mcgs_mode_type;

  // control word: bits 9..0 in the order declared from the top
  typedef struct packed {
    logic       int_ref_enable;
    logic       fll_ref_select;
    logic [1:0] clock_mode_select;
    logic [1:0] osc_freq_range;
    logic       osc_high_gain;
    logic       ext_ref_source_select;
    logic       low_power_select;
    logic       int_ref_speed_select;
  } mcgs_ctrl_type;

  // trim and range outputs toward the analog oscillators
  typedef struct packed {
    logic       dco_max_tune;
    logic [1:0] dco_range;
    logic [3:0] fast_ref_trim;
    logic       slow_ref_fine_trim;
  } mcgs_trim_type;
endpackage

/* File: design/mcgs_top.sv */
// clock generator mode control, status and peripheral clock selection with AHB-Lite registers
`timescale 1ns/100ps
`include "mcgs_regs.svh"
module mcgs_top #(
  parameter int INIT_CYCLES = `MCGS_INIT_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  input  wire logic                  xtal_i,
  input  wire logic [`MCGS_NSRC-1:0] src_clk_i,
  output logic                       fll_enable_o,
  output mcgs_pkg::mcgs_trim_type    trim_o,
  output logic                       uart_clk_o,
  output logic                       tpm_clk_o,
  output logic                       clkout_o,
  output logic                       rtc_clock_output_pin_o
);
  import mcgs_pkg::*;

  mcgs_ctrl_type ctrl_r;
  logic [31:0]   osc_r;
  logic [31:0]   dco_r;
  logic [31:0]   psel_r;
  mcgs_mode_type mode_r;
  mcgs_mode_type mode_nxt;
  logic          pend_r;
  logic          pend_wr_r;
  logic [7:0]    pend_addr_r;
  logic [1:0]    xtal_sync_r;
  logic          xtal_prev_r;
  logic [12:0]   init_cnt_r;
  logic          osc_ready_r;
  logic [`MCGS_NSRC-1:0] src_meta_r;
  logic [`MCGS_NSRC-1:0] src_r;
  logic          bus_div_r;
  logic [1:0]    mode_s1_r;
  logic [1:0]    mode_st_r;
  logic          fref_s1_r;
  logic          fref_st_r;
  logic          int_ref_speed_select_s1_r;
  logic          int_ref_speed_select_st_r;
  logic [1:0]    drs_s1_r;
  logic [1:0]    drs_st_r;
  logic          osc_on;
  logic          irc_on;
  logic          ext_clk;
  logic          irc_clk;
  logic          accept;
  logic [1:0]    uart_sel;
  logic [1:0]    tpm_sel;
  logic [2:0]    clko_sel;
  logic          rtc_sel;
  logic [1:0]    drs_req;

  // four-way peripheral source: off, FLL, external ref, internal ref
  function automatic logic src4(input logic [1:0] sel, input logic fll,
                                input logic ext, input logic irc);
    logic r;
    r = 1'b0;
    case (sel)
      2'b01:   r = fll;
      2'b10:   r = ext;
      2'b11:   r = irc;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] mode_code(input mcgs_mode_type m);
    logic [1:0] c;
    c = 2'b00;
    case (m)
      MCGS_FBI, MCGS_BYPASSED_LOW_POWER_INTERNAL_MODE: c = 2'b01;
      MCGS_FBE, MCGS_BYPASSED_LOW_POWER_EXTERNAL_MODE: c = 2'b10;
      default:             c = 2'b00;
    endcase
    return c;
  endfunction

  // ---------------- bus slave ----------------
  // every transfer takes one wait state, so a read right after a write sees it
  assign accept = hsel_i && htrans_i[1] && hready_i && !pend_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_r      <= 1'b0;
      pend_wr_r   <= 1'b0;
      pend_addr_r <= 8'h00;
      hreadyout_o <= 1'b1;
    end else if (accept) begin
      pend_r      <= 1'b1;
      pend_wr_r   <= hwrite_i;
      pend_addr_r <= haddr_i[7:0];
      hreadyout_o <= 1'b0;
    end else begin
      pend_r      <= 1'b0;
      hreadyout_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (pend_r && !pend_wr_r) begin
      case (pend_addr_r)
        `MCGS_A_CTRL: hrdata_o <= {22'h00_0000, ctrl_r};
        `MCGS_A_OSC:  hrdata_o <= osc_r;
        `MCGS_A_STAT: hrdata_o <= {27'h000_0000, fref_st_r, mode_st_r,
                                   osc_ready_r, int_ref_speed_select_st_r}; // R3 R4 R5 R6
        `MCGS_A_DCO:  hrdata_o <= {dco_r[31:7], drs_st_r, dco_r[4:0]}; // R12
        `MCGS_A_PSEL: hrdata_o <= psel_r;
        default:      hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // reserved bits are masked off on write so they read back as zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= mcgs_ctrl_type'(10'(`MCGS_CTRL_RST));
      osc_r  <= 32'h0000_0000;
      psel_r <= `MCGS_PSEL_RST;
    end else if (pend_r && pend_wr_r) begin
      if (pend_addr_r == `MCGS_A_CTRL)
        ctrl_r <= mcgs_ctrl_type'(hwdata_i[9:0]);
      if (pend_addr_r == `MCGS_A_OSC)
        osc_r <= hwdata_i & `MCGS_OSC_MASK; // R16
      if (pend_addr_r == `MCGS_A_PSEL)
        psel_r <= hwdata_i & `MCGS_PSEL_MASK; // R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dco_r <= `MCGS_DCO_RST;
    end else if (pend_r && pend_wr_r && pend_addr_r == `MCGS_A_DCO) begin
      if (ctrl_r.low_power_select)
        dco_r <= ((hwdata_i & `MCGS_DCO_MASK) & ~`MCGS_DCO_RNG_MASK)
                 | (dco_r & `MCGS_DCO_RNG_MASK); // R13
      else
        dco_r <= hwdata_i & `MCGS_DCO_MASK; // R11 R12 R14 R15 R16
    end
  end

  // ---------------- mode control ----------------
  always_comb begin
    mode_nxt = mode_r;
    case (ctrl_r.clock_mode_select)
      2'b00: mode_nxt = ctrl_r.fll_ref_select ? MCGS_FEI : MCGS_FEE;
      2'b01: mode_nxt = ctrl_r.low_power_select ? MCGS_BYPASSED_LOW_POWER_INTERNAL_MODE : MCGS_FBI; // R19
      2'b10: mode_nxt = ctrl_r.low_power_select ? MCGS_BYPASSED_LOW_POWER_EXTERNAL_MODE : MCGS_FBE; // R19
      default: mode_nxt = mode_r; // reserved select keeps the current mode
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_r <= MCGS_FEI;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fll_enable_o <= 1'b1;
    end else begin
      fll_enable_o <= !(mode_r == MCGS_BYPASSED_LOW_POWER_INTERNAL_MODE || mode_r == MCGS_BYPASSED_LOW_POWER_EXTERNAL_MODE); // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      trim_o <= mcgs_trim_type'(8'(`MCGS_DCO_RST));
    end else begin
      trim_o <= mcgs_trim_type'(dco_r[7:0]); // R11 R14 R15
    end
  end

  // ---------------- status synchronisers ----------------
  assign irc_on = ctrl_r.int_ref_enable || ctrl_r.fll_ref_select
                  || ctrl_r.clock_mode_select == 2'b01;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_s1_r <= 2'b00;
      mode_st_r <= 2'b00;
      fref_s1_r <= 1'b1;
      fref_st_r <= 1'b1;
      drs_s1_r  <= 2'b00;
      drs_st_r  <= 2'b00;
    end else begin
      mode_s1_r <= mode_code(mode_r);
      mode_st_r <= mode_s1_r; // R4 R20
      fref_s1_r <= ctrl_r.fll_ref_select;
      fref_st_r <= fref_s1_r; // R3 R20
      drs_s1_r  <= drs_req;
      drs_st_r  <= drs_s1_r; // R12 R20
    end
  end

  // the speed status freezes while the internal reference is stopped
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      int_ref_speed_select_s1_r <= 1'b0;
      int_ref_speed_select_st_r <= 1'b0;
    end else if (irc_on) begin
      int_ref_speed_select_s1_r <= ctrl_r.int_ref_speed_select;
      int_ref_speed_select_st_r <= int_ref_speed_select_s1_r; // R6 R20
    end
  end

  // ---------------- oscillator start-up ----------------
  assign osc_on = osc_r[`MCGS_OSC_EN_BIT] || ctrl_r.ext_ref_source_select;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      xtal_sync_r <= 2'b00;
      xtal_prev_r <= 1'b0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[0], xtal_i};
      xtal_prev_r <= xtal_sync_r[1];
    end
  end

  // counts rising edges of the crystal; restarts whenever the oscillator is off
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !osc_on) begin
      init_cnt_r  <= 13'h0000;
      osc_ready_r <= 1'b0; // R5
    end else if (!osc_ready_r && xtal_sync_r[1] && !xtal_prev_r) begin
      if (init_cnt_r == 13'(INIT_CYCLES - 1))
        osc_ready_r <= 1'b1; // R5 R18
      init_cnt_r <= init_cnt_r + 13'h0001;
    end
  end

  // field views of the select registers, decoded once
  assign uart_sel = psel_r[`MCGS_UART_LSB +: 2];
  assign tpm_sel  = psel_r[`MCGS_TPM_LSB +: 2];
  assign clko_sel = psel_r[`MCGS_CLKO_LSB +: 3];
  assign rtc_sel  = psel_r[`MCGS_RTC_BIT];
  assign drs_req  = dco_r[`MCGS_DRS_LSB +: 2];

  // ---------------- clock selection ----------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      src_meta_r <= '0;
      src_r      <= '0;
      bus_div_r  <= 1'b0;
    end else begin
      src_meta_r <= src_clk_i;
      src_r      <= src_meta_r;
      bus_div_r  <= !bus_div_r;
    end
  end

  // external reference passes only once the oscillator is ready
  assign ext_clk = src_r[`MCGS_SRC_EXT] && osc_ready_r
                   && osc_r[`MCGS_OSC_EN_BIT]; // R18
  assign irc_clk = irc_on && (ctrl_r.int_ref_speed_select ?
                   src_r[`MCGS_SRC_IRF] : src_r[`MCGS_SRC_IRS]); // R2

  // outputs are sampled copies, so only sources well below half of clk_i pass cleanly
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      uart_clk_o   <= 1'b0;
      tpm_clk_o    <= 1'b0;
      clkout_o     <= 1'b0;
      rtc_clock_output_pin_o <= 1'b0;
    end else begin
      uart_clk_o <= src4(uart_sel, src_r[`MCGS_SRC_FLL], ext_clk, irc_clk); // R7
      tpm_clk_o  <= src4(tpm_sel, src_r[`MCGS_SRC_FLL], ext_clk, irc_clk); // R8
      case (clko_sel)
        3'b010:  clkout_o <= bus_div_r; // R9
        3'b011:  clkout_o <= src_r[`MCGS_SRC_LPO]; // R9
        3'b100:  clkout_o <= irc_clk; // R9
        3'b110:  clkout_o <= ext_clk; // R9
        default: clkout_o <= 1'b0;
      endcase
      rtc_clock_output_pin_o <= rtc_sel ? ext_clk : src_r[`MCGS_SRC_RTC]; // R10
    end
  end
endmodule // mcgs_top

/* File: test/mcgs_asserts.sv */
// concurrent checks on the ports of the clock generator/select block
`timescale 1ns/100ps
`include "mcgs_regs.svh"
module mcgs_checker #(
  parameter int INIT_CYCLES = 8
) (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   hsel_i,
  input wire logic [31:0]            haddr_i,
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire logic [2:0]             hsize_i,
  input wire logic [31:0]            hwdata_i,
  input wire logic                   hready_i,
  input wire logic [31:0]            hrdata_o,
  input wire logic                   hreadyout_o,
  input wire logic                   hresp_o,
  input wire logic                   xtal_i,
  input wire logic [`MCGS_NSRC-1:0]  src_clk_i,
  input wire logic                   fll_enable_o,
  input wire mcgs_pkg::mcgs_trim_type trim_o,
  input wire logic                   uart_clk_o,
  input wire logic                   tpm_clk_o,
  input wire logic                   clkout_o,
  input wire logic                   rtc_clock_output_pin_o
);
  logic        act_r;
  logic        wr_r;
  logic [7:0]  adr_r;
  logic [31:0] ctrl_r;
  logic [31:0] psel_r;
  wire         cm = act_r & hreadyout_o;
  wire         dco_cm = cm & wr_r & (adr_r == 8'h0C);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // track the data phase so writes can be shadowed at the edge they commit
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) act_r <= 1'b0;
    else if (hsel_i & htrans_i[1] & hready_i) begin
      act_r <= 1'b1;
      wr_r  <= hwrite_i;
      adr_r <= haddr_i[7:0];
    end else if (cm) act_r <= 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `MCGS_CTRL_RST;
      psel_r <= 32'h0;
    end else if (cm & wr_r) begin
      if (adr_r == 8'h00) ctrl_r <= hwdata_i;
      if (adr_r == 8'h10) psel_r <= hwdata_i;
    end
  end
  property p_fll_on; (!ctrl_r[1])[*8] |-> fll_enable_o; endproperty
  a_fll_on: assert property (p_fll_on) else $error("fll off while low power clear");
  property p_uart_off; (psel_r[27:26] == 2'b00)[*8] |-> !uart_clk_o; endproperty
  a_uart_off: assert property (p_uart_off) else $error("uart clock not gated");
  property p_tpm_off; (psel_r[25:24] == 2'b00)[*8] |-> !tpm_clk_o; endproperty
  a_tpm_off: assert property (p_tpm_off) else $error("timer clock not gated");
  property p_bus_clk; (psel_r[7:5] == 3'b010)[*8] |-> clkout_o != $past(clkout_o); endproperty
  a_bus_clk: assert property (p_bus_clk) else $error("bus clock not on output pin");
  property p_trim_rst; $rose(rst_b_i) |-> trim_o == 8'h00; endproperty
  a_trim_rst: assert property (p_trim_rst) else $error("trim not cleared by reset");
  property p_trim_wr;
    dco_cm |-> ##2 {trim_o[7], trim_o[4:0]} == $past({hwdata_i[7], hwdata_i[4:0]}, 2);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim bits differ from write");
  property p_rng_wr;
    dco_cm && !ctrl_r[1] |-> ##2 trim_o.dco_range == $past(hwdata_i[6:5], 2);
  endproperty
  a_rng_wr: assert property (p_rng_wr) else $error("dco range not written");
  property p_rng_hold;
    dco_cm && ctrl_r[1] |-> ##2 trim_o.dco_range == $past(trim_o.dco_range, 2);
  endproperty
  a_rng_hold: assert property (p_rng_hold) else $error("dco range changed in low power");
endmodule // mcgs_checker
bind mcgs_top mcgs_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk_i, .rst_b_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .xtal_i, .src_clk_i, .fll_enable_o, .trim_o, .uart_clk_o, .tpm_clk_o,
  .clkout_o, .rtc_clock_output_pin_o);

/* File: test/test_mcu_clock_generator_select.sv */
// self-checking bench for the clock generator/select block
`timescale 1ns/100ps
`include "mcgs_regs.svh"
module test_mcu_clock_generator_select;
  import mcgs_pkg::*;
  logic          clk_i = 0, rst_b_i = 0, hsel_i = 0, hwrite_i = 0, xtal_i = 0;
  logic [31:0]   haddr_i = 0, hwdata_i = 0, hrdata_o, m_ctrl, m_osc, m_dco, m_psel, q, d;
  logic [1:0]    htrans_i = 0, ph = 0;
  logic [5:0]    src_clk_i = 0;
  logic [2:0]    c;
  logic          hreadyout_o, hresp_o, fll_enable_o, uart_clk_o, tpm_clk_o, clkout_o;
  logic          rtc_clock_output_pin_o;
  mcgs_trim_type trim_o;
  logic [7:0]    ad [4] = '{8'h00, 8'h04, 8'h0C, 8'h10};
  logic [2:0]    cs [4] = '{3'd2, 3'd3, 3'd4, 3'd6};
  int unsigned   seed = 69;
  int            n_fail = 0, check_count = 0, k;
  // init count shortened so the crystal wait stays brief
  mcgs_top #(.INIT_CYCLES(8)) uut (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .xtal_i, .src_clk_i, .fll_enable_o, .trim_o, .uart_clk_o, .tpm_clk_o, .clkout_o,
    .rtc_clock_output_pin_o);
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ph <= ph + 2'd1;
    xtal_i <= ph[1];
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task waitrdy;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'b10;
    waitrdy;
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    waitrdy;
    q = hrdata_o;
  endtask
  function automatic logic [31:0] ex(input logic [7:0] a);
    case (a)
      8'h00: return m_ctrl;
      8'h04: return m_osc;
      8'h0C: return m_dco;
      8'h10: return m_psel;
      default: return 32'h0;
    endcase
  endfunction
  task wm(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
    case (a)
      8'h00: m_ctrl = wd & `MCGS_CTRL_MASK;
      8'h04: m_osc = wd & `MCGS_OSC_MASK;
      8'h0C: m_dco = m_ctrl[1] ? (wd & 32'h9F) | (m_dco & 32'h60) : wd & 32'hFF;
      8'h10: m_psel = wd & `MCGS_PSEL_MASK;
      default: ;
    endcase
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  function automatic int src_of(input logic [2:0] cd, input int kd);
    if (kd == 2) return cd[0] ? 1 : 5;
    if (kd == 1) return cd == 3 ? 4 : cd == 4 ? 2 : cd == 6 ? 1 : -1;
    return cd == 0 ? -1 : int'(cd) - 1;
  endfunction
  function automatic logic pick(input int i);
    return i < 0 ? 1'b0 : src_clk_i[i];
  endfunction
  initial begin
    m_ctrl = `MCGS_CTRL_RST;
    m_osc = 0;
    m_dco = 0;
    m_psel = 0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 0; a < 24; a += 4) rc(8'(a), a == 8 ? 32'h10 : ex(8'(a)));
    for (int i = 0; i < 16; i++) begin
      d = xs();
      wm(ad[i % 4], d);
      repeat (2) @(posedge clk_i);
      if (i % 4 == 2) chk(trim_o, m_dco[7:0]);
      rc(ad[i % 4], ex(ad[i % 4]));
    end
    wm(8'h00, 32'h100);
    // stop the oscillator first so the ready count restarts from zero
    wm(8'h04, 32'h00);
    wm(8'h04, 32'hA0);
    wm(8'h00, m_ctrl & ~32'h3C);
    wm(8'h00, m_ctrl | 32'h04);
    bus(1'b0, 8'h08, 32'h0);
    chk(q[1], 1'b0);
    for (int n = 0; n < 100 && q[1] !== 1'b1; n++) bus(1'b0, 8'h08, 32'h0);
    chk(q[1], 1'b1);
    wm(8'h00, 32'h304);
    for (int i = 0; i < 12; i++) begin
      d = xs();
      c = cs[d[6:5]];
      wm(8'h10, {4'h0, d[27:24], 16'h0, c, d[4], 4'h0});
      src_clk_i <= d[13:8];
      repeat (8) @(posedge clk_i);
      chk({uart_clk_o, tpm_clk_o, c != 2 && clkout_o, rtc_clock_output_pin_o}, {pick(src_of(d[27:26],
        0)), pick(src_of(d[25:24], 0)), pick(src_of(c, 1)), pick(src_of(d[4], 2))});
    end
    wm(8'h00, 32'h080);
    repeat (6) @(posedge clk_i);
    rc(8'h08, 32'h0A);
    chk(fll_enable_o, 1'b1);
    wm(8'h00, 32'h082);
    repeat (6) @(posedge clk_i);
    chk(fll_enable_o, 1'b0);
    wm(8'h00, 32'h141);
    repeat (6) @(posedge clk_i);
    rc(8'h08, 32'h17);
    chk(fll_enable_o, 1'b1);
    wm(8'h10, 32'h0C00_0000);
    src_clk_i <= 6'h08;
    repeat (6) @(posedge clk_i);
    chk(uart_clk_o, 1'b1);
    wm(8'h00, 32'h143);
    repeat (6) @(posedge clk_i);
    chk(fll_enable_o, 1'b0);
    wm(8'h00, 32'h000);
    repeat (6) @(posedge clk_i);
    rc(8'h08, 32'h03);
    wm(8'h04, 32'h00);
    repeat (6) @(posedge clk_i);
    rc(8'h08, 32'h01);
    report_and_stop;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    report_and_stop;
  end
endmodule // test_mcu_clock_generator_select
